//--- logic/cms_group_seq.sv
// per five-cell group window sequencer
`timescale 1ns/1ps
module cms_group_seq
    import cms_pkg::*;
#(
    parameter int unsigned SLOW_CYC = WIN_SLOW_CYC,
    parameter int unsigned FAST_CYC = WIN_FAST_CYC
)
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // control
    input wire logic run,
    input wire logic frame_start,
    input wire logic [4:0] balance_bits,
    // progress
    output logic [2:0] cell_idx,
    output logic sample_stb,
    output logic busy
);
    logic [31:0] cnt_q;
    logic [2:0] idx_q;
    logic busy_q;
    wire fast_w = |balance_bits;
    wire [31:0] win_w = fast_w ? 32'(FAST_CYC) : 32'(SLOW_CYC);
    wire win_end_w = busy_q && (cnt_q >= win_w - 32'd1);
    wire last_w = idx_q == 3'(CELLS_PER_GROUP - 1);

    assign cell_idx = idx_q;
    assign sample_stb = win_end_w;
    assign busy = busy_q;

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n || !run)
        begin
            cnt_q <= 32'h0000_0000;
            idx_q <= 3'h0;
            busy_q <= 1'b0;
        end
        else if (frame_start)
        begin
            cnt_q <= 32'h0000_0000;
            idx_q <= 3'h0;
            busy_q <= 1'b1;
        end
        else if (win_end_w)
        begin
            cnt_q <= 32'h0000_0000;
            idx_q <= last_w ? 3'h0 : idx_q + 3'h1;
            busy_q <= !last_w;
        end
        else if (busy_q)
        begin
            cnt_q <= cnt_q + 32'd1;
        end
    end

    // window length follows the balance bits of this group only
    fast_window_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (busy_q && fast_w && cnt_q == 32'(FAST_CYC) - 32'd1) |-> sample_stb)
        else $error("fast window did not end on time");
endmodule : cms_group_seq

//--- logic/cms_pkg.sv
// shared constants for the cell measurement scheduler
package cms_pkg;
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned WIN_SLOW_US = 50_000;
    localparam int unsigned WIN_FAST_US = 12_500;
    localparam int unsigned FRAME_US = 250_000;
    localparam int unsigned TEMP_US = 2_000_000;
    localparam int unsigned CC_US = 250_000;
    localparam int unsigned WIN_SLOW_CYC = WIN_SLOW_US * (CLK_HZ / 1_000_000);
    localparam int unsigned WIN_FAST_CYC = WIN_FAST_US * (CLK_HZ / 1_000_000);
    localparam int unsigned FRAME_CYC = FRAME_US * (CLK_HZ / 1_000_000);
    localparam int unsigned TEMP_CYC = TEMP_US * (CLK_HZ / 1_000_000);
    localparam int unsigned CC_CYC = CC_US * (CLK_HZ / 1_000_000);
    localparam int unsigned CELLS_PER_GROUP = 5;
    localparam int unsigned CODE_W = 14;
    localparam int unsigned SUM_W = 16;
    localparam int unsigned CC_W = 16;
    localparam logic [13:0] CODE_RESET = 14'h0000;
    localparam logic [15:0] CC_RESET = 16'h0000;
    typedef enum logic [1:0]
    {
        CMS_CC_IDLE = 2'b00,
        CMS_CC_CONT = 2'b01,
        CMS_CC_SHOT = 2'b10
    } cms_cc_state_t;
endpackage : cms_pkg

//--- logic/cms_scheduler.sv
// measurement scheduler: cell groups, temperature, stack sum, charge counter
`timescale 1ns/1ps
module cms_scheduler
    import cms_pkg::*;
#(
    parameter int unsigned GROUPS = 3,
    parameter int unsigned SLOW_CYC = WIN_SLOW_CYC,
    parameter int unsigned FAST_CYC = WIN_FAST_CYC,
    parameter int unsigned FRAME_LEN = FRAME_CYC,
    parameter int unsigned TEMP_LEN = TEMP_CYC,
    parameter int unsigned CC_LEN = CC_CYC
)
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // mode and control
    input wire logic active_mode,
    input wire logic converter_on_set,
    input wire logic converter_on_clr,
    input wire logic [14:0] balance_bits,
    input wire logic temp_source_sel,
    input wire logic charge_count_continuous,
    input wire logic charge_single_shot,
    input wire logic charge_ready_clr,
    // analog front samples
    input wire logic [13:0] cell_code_in [15],
    input wire logic [13:0] therm_code_in [3],
    input wire logic [13:0] die_code_in [3],
    input wire logic signed [15:0] charge_increment,
    // status and results
    output logic converter_on,
    output logic protect_enable,
    output logic [13:0] cell_result [15],
    output logic [13:0] temp_result_ch [3],
    output logic [15:0] stack_sum_result,
    output logic signed [15:0] charge_counter,
    output logic charge_sample_ready,
    output logic host_alert
);
    localparam int unsigned NCELL = GROUPS * CELLS_PER_GROUP;
    logic adc_on_q;
    logic active_q;
    logic [31:0] frame_cnt_q;
    logic [31:0] temp_cnt_q;
    logic [31:0] cc_cnt_q;
    logic signed [15:0] cc_acc_q;
    logic signed [15:0] cc_res_q;
    logic ready_q;
    cms_cc_state_t cc_state_q;
    cms_cc_state_t cc_state_d;
    logic [13:0] cell_q [15];
    logic [13:0] temp_q [3];
    logic [15:0] sum_q;
    logic pass_q;
    logic take_q;
    logic [GROUPS-1:0] busy_w;
    logic [GROUPS-1:0] stb_w;
    logic [2:0] idx_w [GROUPS];

    wire enter_active_w = active_mode && !active_q;
    wire frame_end_w = frame_cnt_q == 32'(FRAME_LEN) - 32'd1;
    wire frame_start_w = adc_on_q && frame_end_w;
    wire temp_due_w = temp_cnt_q == 32'(TEMP_LEN) - 32'd1;
    wire cc_end_w = cc_state_q != CMS_CC_IDLE
        && cc_cnt_q == 32'(CC_LEN) - 32'd1;

    assign converter_on = adc_on_q;
    assign protect_enable = adc_on_q && active_mode;
    assign cell_result = cell_q;
    assign temp_result_ch = temp_q;
    assign stack_sum_result = sum_q;
    assign charge_counter = cc_res_q;
    assign charge_sample_ready = ready_q;
    assign host_alert = ready_q;

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            adc_on_q <= 1'b0;
            active_q <= 1'b0;
        end
        else
        begin
            active_q <= active_mode;
            if (enter_active_w || converter_on_set)
                adc_on_q <= 1'b1;
            else if (converter_on_clr)
                adc_on_q <= 1'b0;
        end
    end

    // one frame timer shared by all groups keeps them in step
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n || !adc_on_q)
            frame_cnt_q <= 32'h0000_0000;
        else
            frame_cnt_q <= frame_end_w ? 32'h0000_0000 : frame_cnt_q + 32'd1;
    end

    genvar g;
    generate
        for (g = 0; g < GROUPS; g++)
        begin : grp
            cms_group_seq #(
                .SLOW_CYC(SLOW_CYC),
                .FAST_CYC(FAST_CYC)
            ) u_seq (
                .sys_clk(sys_clk),
                .reset_n(reset_n),
                .run(adc_on_q),
                .frame_start(frame_start_w),
                .balance_bits(balance_bits[g*5 +: 5]),
                .cell_idx(idx_w[g]),
                .sample_stb(stb_w[g]),
                .busy(busy_w[g])
            );
        end
    endgenerate

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            for (int i = 0; i < 15; i++)
                cell_q[i] <= CODE_RESET;
        end
        else
        begin
            for (int k = 0; k < GROUPS; k++)
                if (stb_w[k])
                    cell_q[k*5 + int'(idx_w[k])] <=
                        cell_code_in[k*5 + int'(idx_w[k])];
        end
    end

    // total lags to the next frame: with 50 ms windows a pass ends on its edge
    logic [15:0] sum_w;
    always_comb
    begin
        sum_w = 16'h0000;
        for (int i = 0; i < NCELL; i++)
            sum_w = sum_w + 16'(cell_q[i]);
    end

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
            sum_q <= 16'h0000;
        else if (take_q)
            sum_q <= sum_w;
        pass_q <= reset_n && adc_on_q && (pass_q || frame_start_w);
        take_q <= reset_n && adc_on_q && pass_q && frame_start_w;
    end

    // temperature refresh; switching source waits for the next slot
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n || !adc_on_q)
            temp_cnt_q <= 32'h0000_0000;
        else
            temp_cnt_q <= temp_due_w ? 32'h0000_0000 : temp_cnt_q + 32'd1;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            for (int i = 0; i < 3; i++)
                temp_q[i] <= CODE_RESET;
        end
        else if (temp_due_w)
        begin
            for (int i = 0; i < 3; i++)
                if (i < GROUPS)
                    temp_q[i] <= temp_source_sel ? therm_code_in[i]
                        : die_code_in[i];
        end
    end

    // charge counter mode machine
    always_comb
    begin
        cc_state_d = cc_state_q;
        unique case (cc_state_q)
            CMS_CC_IDLE:
            begin
                if (charge_count_continuous)
                    cc_state_d = CMS_CC_CONT;
                else if (charge_single_shot)
                    cc_state_d = CMS_CC_SHOT;
            end
            CMS_CC_CONT:
            begin
                if (!charge_count_continuous && cc_end_w)
                    cc_state_d = CMS_CC_IDLE;
            end
            CMS_CC_SHOT:
            begin
                if (cc_end_w)
                    cc_state_d = charge_count_continuous ? CMS_CC_CONT
                        : CMS_CC_IDLE;
            end
            default: cc_state_d = CMS_CC_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            cc_state_q <= CMS_CC_IDLE;
            cc_cnt_q <= 32'h0000_0000;
            cc_acc_q <= CC_RESET;
            cc_res_q <= CC_RESET;
        end
        else
        begin
            cc_state_q <= cc_state_d;
            if (cc_state_q == CMS_CC_IDLE || cc_end_w)
            begin
                cc_cnt_q <= 32'h0000_0000;
                cc_acc_q <= CC_RESET;
            end
            else
            begin
                cc_cnt_q <= cc_cnt_q + 32'd1;
                cc_acc_q <= cc_acc_q + charge_increment;
            end
            if (cc_end_w)
                cc_res_q <= cc_acc_q + charge_increment;
        end
    end

    // set wins over a clear in the same cycle
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
            ready_q <= 1'b0;
        else if (cc_end_w)
            ready_q <= 1'b1;
        else if (charge_ready_clr)
            ready_q <= 1'b0;
    end

    converter_on_entry_a: assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        (active_mode && !active_q) |=> adc_on_q)
        else $error("converter not on after active entry");
    protect_gate_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        !adc_on_q |-> !protect_enable)
        else $error("protection active with converter off");
    frame_period_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        frame_start_w |-> (busy_w & ~stb_w) == '0)
        else $error("frame start before pass done");
    groups_parallel_a: assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        frame_start_w |=> busy_w == {GROUPS{1'b1}})
        else $error("groups did not start together");
    ready_on_end_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        cc_end_w |=> charge_sample_ready && host_alert)
        else $error("ready not raised after conversion");
    ready_holds_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (ready_q && !charge_ready_clr) |=> ready_q)
        else $error("ready dropped without clear");
    shot_once_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (cc_state_q == CMS_CC_SHOT && cc_end_w && !charge_count_continuous)
        |=> cc_state_q == CMS_CC_IDLE)
        else $error("single shot did not stop");
    cont_period_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (cc_end_w && charge_count_continuous) |=> cc_state_q == CMS_CC_CONT)
        else $error("continuous count paused");
    sum_update_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        take_q |=> stack_sum_result == $past(sum_w))
        else $error("stack sum not stored");
endmodule : cms_scheduler

//--- testbench/cell_measurement_scheduler_test.sv
// self-checking bench for the measurement scheduler
`timescale 1ns/1ps
module cell_measurement_scheduler_test;
    import cms_pkg::*;
    localparam int unsigned CCL = 20;
    localparam int unsigned FRL = 50;
    localparam int unsigned TPL = 200;
    logic sys_clk = 1'b0, reset_n = 1'b0, active_mode = 1'b0;
    logic con_set = 1'b0, con_clr = 1'b0, tsel = 1'b0, cont = 1'b0;
    logic shot = 1'b0, clr, host_en = 1'b0, conv_on, prot, ready, alert;
    logic [14:0] bal = 15'h0000;
    logic [13:0] cell_in [15], therm_in [3], die_in [3];
    logic [13:0] cell_res [15], temp_res [3];
    logic [15:0] sum_res, exp_sum;
    logic signed [15:0] inc = 16'sh0000, cc_res;
    int err_count = 0, tests_run = 0, seed = 32'h0a61;

    cms_scheduler #(.GROUPS(3), .SLOW_CYC(10), .FAST_CYC(3), .FRAME_LEN(FRL),
        .TEMP_LEN(TPL), .CC_LEN(CCL)) i_cms_scheduler (
        .sys_clk(sys_clk), .reset_n(reset_n), .active_mode(active_mode),
        .converter_on_set(con_set), .converter_on_clr(con_clr),
        .balance_bits(bal), .temp_source_sel(tsel),
        .charge_count_continuous(cont), .charge_single_shot(shot),
        .charge_ready_clr(clr), .cell_code_in(cell_in),
        .therm_code_in(therm_in), .die_code_in(die_in),
        .charge_increment(inc), .converter_on(conv_on),
        .protect_enable(prot), .cell_result(cell_res),
        .temp_result_ch(temp_res), .stack_sum_result(sum_res),
        .charge_counter(cc_res), .charge_sample_ready(ready),
        .host_alert(alert));
    cms_host_model i_cms_host_model (.sys_clk(sys_clk), .enable(host_en),
        .host_alert(alert), .charge_ready_clr(clr));

    initial forever #20 sys_clk = ~sys_clk;

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : give_verdict

    // bounded wait on the ready flag, then compare it
    task automatic wait_ready(input logic want);
        int n;
        n = 0;
        while (ready !== want && n < CCL + 10)
        begin
            @(negedge sys_clk);
            n++;
        end
        check({15'h0000, ready}, {15'h0000, want});
        check({15'h0000, alert}, {15'h0000, want});
    endtask : wait_ready

    task automatic cycles(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : cycles

    task automatic fill_codes();
        exp_sum = 16'h0000;
        for (int i = 0; i < 15; i++)
        begin
            // kept below 4096 so the stack total cannot wrap
            cell_in[i] = 14'($random(seed)) & 14'h0fff;
            exp_sum = exp_sum + {2'b00, cell_in[i]};
        end
        for (int i = 0; i < 3; i++)
        begin
            therm_in[i] = 14'($random(seed));
            die_in[i] = 14'($random(seed));
        end
    endtask : fill_codes

    initial
    begin
        fill_codes();
        cycles(20);
        reset_n = 1'b1;
        check({15'h0000, conv_on}, 16'h0000);
        check({15'h0000, ready}, 16'h0000);
        active_mode = 1'b1;
        cycles(2);
        check({15'h0000, conv_on}, 16'h0001);
        check({15'h0000, prot}, 16'h0001);
        con_clr = 1'b1;
        cycles(1);
        con_clr = 1'b0;
        cycles(1);
        check({15'h0000, prot}, 16'h0000);
        con_set = 1'b1;
        cycles(1);
        con_set = 1'b0;
        cycles(1);
        check({15'h0000, prot}, 16'h0001);
        $display("test converter control done");
        // single shots: minus one step, then a random step
        for (int k = 0; k < 2; k++)
        begin
            inc = (k == 0) ? 16'shffff : 16'(($random(seed) % 1000));
            shot = 1'b1;
            cycles(1);
            shot = 1'b0;
            wait_ready(1'b1);
            check(cc_res, 16'(inc * CCL));
            cycles(10);
            check({15'h0000, ready}, 16'h0001);
            host_en = 1'b1;
            wait_ready(1'b0);
            host_en = 1'b0;
        end
        $display("test single shot done");
        inc = 16'(($random(seed) % 500));
        cont = 1'b1;
        host_en = 1'b1;
        for (int k = 0; k < 3; k++)
        begin
            wait_ready(1'b1);
            check(cc_res, 16'(inc * CCL));
            wait_ready(1'b0);
        end
        cont = 1'b0;
        host_en = 1'b0;
        $display("test continuous done");
        // both select settings, random balancing on the second pass
        for (int k = 0; k < 2; k++)
        begin
            tsel = k[0];
            // first pass unbalanced: slow windows fill the frame exactly
            bal = (k == 0) ? 15'h0000 : 15'($random(seed));
            fill_codes();
            cycles(2 * TPL + 20);
            for (int i = 0; i < 15; i++)
                check({2'b00, cell_res[i]}, {2'b00, cell_in[i]});
            check(sum_res, exp_sum);
            for (int i = 0; i < 3; i++)
                check({2'b00, temp_res[i]},
                    {2'b00, tsel ? therm_in[i] : die_in[i]});
        end
        $display("test measurement done");
        give_verdict();
    end

    initial
    begin
        #(40 * 6000);
        err_count++;
        give_verdict();
    end
endmodule : cell_measurement_scheduler_test

//--- testbench/cms_host_model.sv
// host-side model that acknowledges the charge ready flag
`timescale 1ns/1ps
module cms_host_model
    import cms_pkg::*;
(
    // clock
    input wire logic sys_clk,
    // handshake
    input wire logic enable,
    input wire logic host_alert,
    output logic charge_ready_clr
);
    logic [1:0] wait_q = 2'b00;
    initial charge_ready_clr = 1'b0;
    // a slow host: clears only after the alert has stood a while
    always @(negedge sys_clk)
    begin
        charge_ready_clr <= 1'b0;
        if (enable && host_alert && !charge_ready_clr)
        begin
            wait_q <= wait_q + 2'b01;
            if (wait_q == 2'b10)
            begin
                charge_ready_clr <= 1'b1;
                wait_q <= 2'b00;
            end
        end
    end
endmodule : cms_host_model
